// ### verilog/spv_pkg.sv
// Function
// RULE_01 - Blank configuration reads low-voltage entry allowed.
// RULE_02 - Low-voltage enable clears only under high voltage.
// RULE_03 - High-voltage entry always accepted.
// RULE_04 - Low-voltage session keeps master clear enabled.
// RULE_05 - Four 14-bit user words, always readable.
// RULE_06 - Identity word read-only at its address.
// RULE_07 - Identity: part code high, revision low.
// RULE_08 - Configuration word at its fixed address.
// RULE_09 - Erase never touches calibration words.
// RULE_10 - Configuration bit 13 always reads one.
// RULE_11 - Self-write field protects growing low regions.
// RULE_12 - Brown-out level and low-power detector bits.
// RULE_13 - Low-voltage bit allows entry, forces master clear.
// RULE_14 - Code protect makes program reads zero.
// RULE_15 - Pin select forced to master clear by bit 8.
// RULE_16 - Power-up timer enable is active low.
// RULE_17 - Watchdog mode field; software bit only at 01.
// RULE_18 - Brown-out mode field; software bit only at 01.
// RULE_19 - Bit 0 selects external or internal clock.
// RULE_20 - Commands and data travel LSb first.
// RULE_21 - Change after rising edge, sample on falling.
// RULE_22 - Entry resets logic, floats pins, clears address.
// RULE_23 - Commands are six bits, ten codes.
// RULE_24 - Data phase: start, 14 bits, stop.
package spv_pkg;
	// Configuration memory map.
	localparam logic [13:0] A_UID0     = 14'h2000;
	localparam logic [13:0] A_UID3     = 14'h2003;
	localparam logic [13:0] A_ID       = 14'h2006;
	localparam logic [13:0] A_CFG      = 14'h2007;
	localparam logic [13:0] A_CAL1     = 14'h2008;
	localparam logic [13:0] A_CAL2     = 14'h2009;
	localparam logic [13:0] A_PM_LAST  = 14'h1FFF;
	localparam logic [13:0] A_TOP      = 14'h3FFF;
	localparam logic [13:0] A_ZERO     = 14'h0000;
	// Value of an erased word and of a blank configuration word.
	localparam logic [13:0] WORD_BLANK = 14'h3FFF;
	localparam logic [13:0] CFG_BLANK  = 14'h3DFF;
	localparam logic [13:0] CFG_UNIMPL = 14'h2000;
	// Six-bit commands; the top bit is a don't-care, so five are compared.
	localparam logic [4:0] CMD_LOAD_CFG  = 5'h00;
	localparam logic [4:0] CMD_LOAD_PM   = 5'h02;
	localparam logic [4:0] CMD_READ      = 5'h04;
	localparam logic [4:0] CMD_INC       = 5'h06;
	localparam logic [4:0] CMD_RST_ADDR  = 5'h16;
	localparam logic [4:0] CMD_BEGIN_INT = 5'h08;
	localparam logic [4:0] CMD_BEGIN_EXT = 5'h18;
	localparam logic [4:0] CMD_END_EXT   = 5'h0A;
	localparam logic [4:0] CMD_BULK      = 5'h09;
	localparam logic [4:0] CMD_ROW       = 5'h11;
	// Clock counts of the serial frames.
	localparam logic [4:0] CMD_CLKS      = 5'h06;
	localparam logic [4:0] DATA_CLKS     = 5'h10;
	localparam logic [4:0] TX_LAST_CNT   = 5'h0F;
	// Encodings of the watchdog and brown-out mode fields.
	localparam logic [1:0] MODE_ALWAYS   = 2'h3;
	localparam logic [1:0] MODE_RUN      = 2'h2;
	localparam logic [1:0] MODE_SW       = 2'h1;
	// Configuration word layout, bit 13 down to bit 0.
	typedef struct packed {
		logic       unimpl;
		logic [1:0] self_write_protect_sel;
		logic       brownout_level_sel;
		logic       low_power_brownout_enable;
		logic       low_voltage_prog_enable;
		logic       code_protect_n;
		logic       master_clear_pin_select;
		logic       powerup_timer_enable_n;
		logic [1:0] watchdog_mode_sel;
		logic [1:0] brownout_mode_sel;
		logic       osc_source_sel;
	} spv_cfg_t;
	// Operations handed to the program array.
	typedef enum logic [1:0] {OP_WRITE, OP_BULK, OP_ROW} spv_op_t;
	typedef struct packed {
		spv_op_t     op;
		logic [13:0] addr;
		logic [13:0] data;
	} spv_mem_req_t;
	// Serial engine states.
	typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_RX, ST_TX, ST_PUSH} spv_state_t;
endpackage

// ### verilog/spv_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO with valid/ready on both sides.
module spv_fifo import spv_pkg::*; #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in,
	output logic      [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	// Pointer arithmetic wraps, so the depth must be a power of two.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO depth must be a power of two, at least 2.");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words.
		logic [AW-1:0]               wp;  // Write pointer.
		logic [AW-1:0]               rp;  // Read pointer.
		logic [AW:0]                 cnt; // Words held.
	} spv_fifo_st_t;

	spv_fifo_st_t q;
	spv_fifo_st_t d;
	logic         push;
	logic         pop;

	// Full and empty come straight from the word count, so they never lie.
	assign wr_ready_out = (q.cnt != DEPTH[AW:0]);
	assign rd_valid_out = (q.cnt != '0);
	assign rd_data_out  = q.mem[q.rp];
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;

	// Next-state logic for storage, pointers and count.
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = wr_data_in;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// State register.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// ### verilog/spv_core.sv
`timescale 1ns/1ps
`default_nettype none
// Device side of the two-wire program/verify port and configuration memory.
module spv_core import spv_pkg::*; #(
	parameter int         ARRAY_WORDS = 512,
	parameter int         FIFO_DEPTH  = 4,
	parameter logic [8:0] PART_CODE   = 9'h0A5,  // Arbitrary value.
	parameter logic [4:0] REV_CODE    = 5'h01,   // Arbitrary value.
	parameter logic [13:0] CAL1_WORD  = 14'h1000,
	parameter logic [13:0] CAL2_WORD  = 14'h2000
) (
	input  wire logic          clk_sys_in,
	input  wire logic          sys_rst_in,
	input  wire logic          prog_serial_clock_pin_in,
	input  wire logic          prog_serial_data_pin_in,
	output logic               prog_serial_data_pin_out,
	output logic               prog_serial_data_pin_oe_n_out,
	input  wire logic          master_clear_pin_hv_in,
	input  wire logic          master_clear_pin_low_in,
	input  wire logic          lv_key_ok_in,
	input  wire logic          sleep_in,
	input  wire logic          software_watchdog_enable_in,
	input  wire logic          software_brownout_enable_in,
	output logic               prog_mode_out,
	output logic               lv_mode_out,
	output logic               core_reset_out,
	output logic               io_hiz_out,
	output logic               master_clear_enable_out,
	output logic               gp_input_enable_out,
	output spv_cfg_t           cfg_out,
	output logic [9:0]         wp_limit_out,
	output logic               watchdog_active_out,
	output logic               brownout_active_out,
	output logic               brownout_2v7_out,
	output logic               lp_brownout_on_out,
	output logic               powerup_timer_on_out,
	output logic               ext_clock_sel_out,
	output logic [13:0]        mem_rd_addr_out,
	input  wire logic [13:0]   mem_rd_data_in,
	output spv_mem_req_t       mem_req_out,
	output logic               mem_req_valid_out,
	input  wire logic          mem_req_ready_in
);
	// Only the two documented array sizes have defined protection bounds.
	if (ARRAY_WORDS != 256 && ARRAY_WORDS != 512) begin : g_bad_size
		$error("ARRAY_WORDS must be 256 or 512.");
	end

	typedef struct packed {
		logic [2:0]       ck;      // Clock pin: sync stages and previous.
		logic [1:0]       dt;      // Data pin sync stages.
		logic [1:0]       hv;      // High-voltage detect sync stages.
		logic [1:0]       lo;      // Master clear low sync stages.
		logic             in_prog; // Program/verify session active.
		logic             lv_mode; // Session entered at low voltage.
		spv_state_t       st;      // Serial engine state.
		logic [4:0]       cnt;     // Falling edges in the current frame.
		logic [15:0]      sh;      // Shift register, LSb on the wire first.
		logic [13:0]      addr;    // Internal address counter.
		logic [13:0]      latch;   // Data latch for programming.
		spv_op_t          op;      // Operation waiting for the FIFO.
		logic [3:0][13:0] uid;     // User identification words.
		spv_cfg_t         cfg;     // Configuration word.
		logic             oe_n;    // Data pin output enable, low drives.
		logic             dout;    // Data pin output level.
	} spv_core_st_t;

	spv_core_st_t  q;
	spv_core_st_t  d;
	logic [13:0]   rd_w;
	logic          fifo_rdy;
	logic          rise;
	logic          fall;
	logic          hv_on;
	logic          lv_on;
	logic [4:0]    cmd;
	logic [13:0]   wdata;
	spv_mem_req_t  req;

	// Increment wraps inside the program region and inside the config region.
	function automatic logic [13:0] next_addr(input logic [13:0] a);
		if (a == A_PM_LAST) begin
			return A_ZERO;
		end else if (a == A_TOP) begin
			return A_UID0;
		end
		return a + 14'h0001;
	endfunction

	// Shared decode of the watchdog and brown-out mode fields.
	function automatic logic mode_on(input logic [1:0] sel, input logic sw, input logic slp);
		case (sel)
			MODE_ALWAYS: return 1'b1;
			MODE_RUN:    return !slp;
			MODE_SW:     return sw;
			default:     return 1'b0;
		endcase
	endfunction

	// Number of low program words locked against self-write.
	function automatic logic [9:0] wp_words(input logic [1:0] sel);
		case (sel)
			2'h3:    return 10'h000;
			2'h2:    return 10'(ARRAY_WORDS / 4);
			2'h1:    return 10'(ARRAY_WORDS / 2);
			default: return 10'(ARRAY_WORDS);
		endcase
	endfunction

	// Edges of the synchronised programming clock; the first stage is never read here.
	assign rise  = q.ck[1] && !q.ck[2];
	assign fall  = !q.ck[1] && q.ck[2];
	// Session requests: high voltage always wins, low voltage needs the enable bit.
	assign hv_on = q.hv[1]; // RULE_03
	assign lv_on = q.lo[1] && (q.lv_mode || (q.cfg.low_voltage_prog_enable && lv_key_ok_in)); // RULE_13
	// Command bits as they stand once the fifth bit is in; taken from q to avoid a loop through d.
	assign cmd   = q.sh[15:11]; // RULE_23
	// Data bits between start and stop, as they stand once the fifteenth bit is in.
	assign wdata = q.sh[15:2]; // RULE_24
	assign req   = '{op: q.op, addr: q.addr, data: q.latch};

	// Read mux for the address counter.
	always_comb begin
		rd_w = 14'h0000;
		if (q.addr < A_UID0) begin
			rd_w = q.cfg.code_protect_n ? mem_rd_data_in : 14'h0000; // RULE_14
		end else if (q.addr <= A_UID3) begin
			rd_w = q.uid[q.addr[1:0]]; // RULE_05
		end else if (q.addr == A_ID) begin
			rd_w = {PART_CODE, REV_CODE}; // RULE_06 RULE_07
		end else if (q.addr == A_CFG) begin
			rd_w = q.cfg | CFG_UNIMPL; // RULE_08 RULE_10
		end else if (q.addr == A_CAL1) begin
			rd_w = CAL1_WORD;
		end else if (q.addr == A_CAL2) begin
			rd_w = CAL2_WORD;
		end
	end

	// Main next-state logic: synchronisers, session control and serial engine.
	always_comb begin
		d = q;
		d.ck = {q.ck[1], q.ck[0], prog_serial_clock_pin_in};
		d.dt = {q.dt[0], prog_serial_data_pin_in};
		d.hv = {q.hv[0], master_clear_pin_hv_in};
		d.lo = {q.lo[0], master_clear_pin_low_in};
		d.in_prog = hv_on || lv_on;
		d.lv_mode = !hv_on && lv_on;
		if (!d.in_prog) begin
			// Leaving the session floats the pin and parks the engine.
			d.st   = ST_IDLE;
			d.oe_n = 1'b1;
		end else if (!q.in_prog) begin
			// Fresh entry starts from address zero with the pin released.
			d.addr = A_ZERO; // RULE_22
			d.st   = ST_CMD;
			d.cnt  = 5'h00;
			d.oe_n = 1'b1;
		end else begin
			case (q.st)
				ST_CMD: begin
					if (fall) begin
						// Sampled on the falling edge and shifted in from the top.
						d.sh  = {q.dt[1], q.sh[15:1]}; // RULE_20 RULE_21
						d.cnt = q.cnt + 5'h01;
						if (d.cnt == CMD_CLKS) begin
							d.cnt = 5'h00;
							case (cmd) // RULE_23
								CMD_LOAD_CFG: begin
									d.addr = A_UID0;
									d.st   = ST_RX;
								end
								CMD_LOAD_PM: begin
									d.st = ST_RX;
								end
								CMD_READ: begin
									d.st = ST_TX;
								end
								CMD_INC: begin
									d.addr = next_addr(q.addr);
								end
								CMD_RST_ADDR: begin
									d.addr = A_ZERO;
								end
								CMD_BEGIN_INT, CMD_BEGIN_EXT: begin
									if (q.addr < A_UID0) begin
										d.op = OP_WRITE;
										d.st = ST_PUSH;
									end else if (cmd == CMD_BEGIN_INT && q.addr <= A_UID3) begin
										d.uid[q.addr[1:0]] = q.latch; // RULE_05
									end else if (cmd == CMD_BEGIN_INT && q.addr == A_CFG) begin
										d.cfg = q.latch | CFG_UNIMPL; // RULE_10
										// A low-voltage session can never drop its own enable.
										if (q.lv_mode) begin
											d.cfg.low_voltage_prog_enable = q.cfg.low_voltage_prog_enable; // RULE_02
										end
									end
								end
								CMD_BULK: begin
									// Calibration words are parameters and stay as they are.
									d.uid = {4{WORD_BLANK}}; // RULE_09
									d.cfg = CFG_BLANK; // RULE_01
									d.op  = OP_BULK;
									d.st  = ST_PUSH;
								end
								CMD_ROW: begin
									d.op = OP_ROW;
									d.st = ST_PUSH;
								end
								default: begin
									d.st = ST_CMD;
								end
							endcase
						end
					end
				end
				ST_RX: begin
					if (fall) begin
						d.sh  = {q.dt[1], q.sh[15:1]}; // RULE_20 RULE_21
						d.cnt = q.cnt + 5'h01;
						if (d.cnt == DATA_CLKS) begin // RULE_24
							d.latch = wdata;
							d.cnt   = 5'h00;
							d.st    = ST_CMD;
						end
					end
				end
				ST_TX: begin
					if (fall) begin
						d.cnt = q.cnt + 5'h01;
						if (q.cnt == 5'h00) begin
							// First falling edge takes the pin and drives the start bit.
							d.oe_n = 1'b0;
							d.dout = 1'b0;
							d.sh   = {2'h0, rd_w};
						end else if (d.cnt == DATA_CLKS) begin
							// Sixteenth falling edge hands the pin back.
							d.oe_n = 1'b1; // RULE_24
							d.cnt  = 5'h00;
							d.st   = ST_CMD;
						end
					end else if (rise && q.cnt != 5'h00) begin
						// Change after the rising edge; the zero loaded above bit 13 of the word makes the stop bit.
						d.dout = q.sh[0]; // RULE_20 RULE_21
						d.sh   = {1'b0, q.sh[15:1]};
					end
				end
				ST_PUSH: begin
					// Serial edges are ignored while the array queue is full.
					if (fifo_rdy) begin
						d.st = ST_CMD;
					end
				end
				default: begin
					d.st = ST_CMD;
				end
			endcase
		end
	end

	// State register; a blank device comes out of reset.
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			q       <= '0;
			q.uid   <= {4{WORD_BLANK}};
			q.cfg   <= CFG_BLANK; // RULE_01
			q.st    <= ST_IDLE;
			q.oe_n  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Queue between the serial engine and the slower program array.
	spv_fifo #(
		.WIDTH($bits(spv_mem_req_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in   (clk_sys_in),
		.sys_rst_in   (sys_rst_in),
		.wr_valid_in  (q.st == ST_PUSH),
		.wr_ready_out (fifo_rdy),
		.wr_data_in   (req),
		.rd_valid_out (mem_req_valid_out),
		.rd_ready_in  (mem_req_ready_in),
		.rd_data_out  (mem_req_out)
	);

	// Pin and session outputs.
	assign prog_serial_data_pin_out      = q.dout;
	assign prog_serial_data_pin_oe_n_out = q.oe_n;
	assign prog_mode_out                 = q.in_prog;
	assign lv_mode_out                   = q.lv_mode;
	assign core_reset_out                = q.in_prog; // RULE_22
	assign io_hiz_out                    = q.in_prog; // RULE_22
	assign mem_rd_addr_out               = q.addr;
	// Master clear function: forced by the enable bit and by a low-voltage session.
	assign master_clear_enable_out = q.cfg.master_clear_pin_select
		|| q.cfg.low_voltage_prog_enable || q.lv_mode; // RULE_04 RULE_13 RULE_15
	assign gp_input_enable_out     = !master_clear_enable_out; // RULE_04
	// Decoded configuration fields for the rest of the device.
	assign cfg_out              = q.cfg | CFG_UNIMPL; // RULE_10
	assign wp_limit_out         = wp_words(q.cfg.self_write_protect_sel); // RULE_11
	assign watchdog_active_out  = mode_on(q.cfg.watchdog_mode_sel,
		software_watchdog_enable_in, sleep_in); // RULE_17
	assign brownout_active_out  = mode_on(q.cfg.brownout_mode_sel,
		software_brownout_enable_in, sleep_in); // RULE_18
	assign brownout_2v7_out     = !q.cfg.brownout_level_sel; // RULE_12
	assign lp_brownout_on_out   = q.cfg.low_power_brownout_enable; // RULE_12
	assign powerup_timer_on_out = !q.cfg.powerup_timer_enable_n; // RULE_16
	assign ext_clock_sel_out    = q.cfg.osc_source_sel; // RULE_19

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_entry;
		!q.in_prog ##1 q.in_prog;
	endsequence
	sequence s_tx_end;
		q.in_prog && $rose(q.oe_n);
	endsequence

	property p_blank_lvp;
		$past(sys_rst_in) |-> q.cfg.low_voltage_prog_enable;
	endproperty
	a_blank_lvp: assert property (p_blank_lvp) else $error("Blank device lacks LV enable."); // RULE_01
	property p_lvp_clear;
		$fell(q.cfg.low_voltage_prog_enable) |-> $past(q.in_prog) && !$past(q.lv_mode);
	endproperty
	a_lvp_clear: assert property (p_lvp_clear) else $error("LV enable cleared outside HV."); // RULE_02
	property p_hv_entry;
		q.hv[1] |=> q.in_prog && !q.lv_mode;
	endproperty
	a_hv_entry: assert property (p_hv_entry) else $error("High-voltage entry refused."); // RULE_03
	property p_lv_master_clear_pin;
		q.lv_mode |-> master_clear_enable_out && !gp_input_enable_out;
	endproperty
	a_lv_master_clear_pin: assert property (p_lv_master_clear_pin) else $error("Master clear off in LV session."); // RULE_04
	property p_uid;
		(q.addr >= A_UID0 && q.addr <= A_UID3) |-> rd_w == q.uid[q.addr[1:0]];
	endproperty
	a_uid: assert property (p_uid) else $error("User word read wrong."); // RULE_05
	property p_id;
		q.addr == A_ID |-> rd_w == {PART_CODE, REV_CODE};
	endproperty
	a_id: assert property (p_id) else $error("Identity word read wrong."); // RULE_07
	property p_bit13;
		q.addr == A_CFG |-> rd_w[13] && cfg_out.unimpl;
	endproperty
	a_bit13: assert property (p_bit13) else $error("Config bit 13 not one."); // RULE_10
	property p_cp;
		(q.addr < A_UID0 && !q.cfg.code_protect_n) |-> rd_w == 14'h0000;
	endproperty
	a_cp: assert property (p_cp) else $error("Protected read not zero."); // RULE_14
	property p_wdt;
		q.cfg.watchdog_mode_sel == MODE_SW |-> watchdog_active_out == software_watchdog_enable_in;
	endproperty
	a_wdt: assert property (p_wdt) else $error("Watchdog ignores software bit."); // RULE_17
	property p_entry;
		s_entry |-> q.addr == A_ZERO && core_reset_out && io_hiz_out && q.oe_n;
	endproperty
	a_entry: assert property (p_entry) else $error("Entry did not clear state."); // RULE_22
	property p_tx_end;
		s_tx_end |-> $past(q.cnt) == TX_LAST_CNT && q.st == ST_CMD;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("Read frame length wrong."); // RULE_24
endmodule
`default_nettype wire

// ### tb/spv_prog.sv
`timescale 1ns/1ps
`default_nettype none
// Programmer model: it makes the serial clock only inside frames and holds it low between them.
module spv_prog (
	output logic      sclk_out,
	output logic      sdat_out,
	input  wire logic sdat_in
);
	// The clock rests low so the device sees no stray edge before a frame.
	initial begin
		sclk_out = 1'b0;
		sdat_out = 1'b0;
	end
	// One 64 ns clock: data moves just after the rise and is sampled at the fall.
	task automatic tick(input logic b, output logic s);
		sclk_out = 1'b1;
		#2 sdat_out = b;
		#30 sclk_out = 1'b0;
		s = sdat_in;
		#32;
	endtask
	// Sends the low n bits of a value, least significant first.
	task automatic send(input logic [15:0] v, input int n);
		logic s;
		for (int i = 0; i < n; i++) tick(v[i], s);
	endtask
	// A six-bit command followed by a framed 14-bit word.
	task automatic load(input logic [4:0] c, input logic [13:0] d);
		send({11'h000, c}, 6);
		send({1'b0, d, 1'b0}, 16);
	endtask
	// Read: the word sits on falls 2 to 15; our own drive toggles so a floating line fails.
	task automatic read(output logic [13:0] d);
		logic [15:0] w;
		send(16'h0004, 6);
		for (int i = 0; i < 16; i++) tick(~sdat_out, w[i]);
		d = w[14:1];
	endtask
endmodule
`default_nettype wire

// ### tb/tb_serial_program_verify_config_memory.sv
`timescale 1ns/1ps
`default_nettype none
// Bench: sessions, configuration decoding, erase and program requests seen at the ports.
module tb_serial_program_verify_config_memory;
	import spv_pkg::*;
	localparam logic [8:0]  PC  = 9'h0C3;   // Arbitrary value.
	localparam logic [13:0] CAL = 14'h1555;
	logic clk_sys_in, sys_rst_in, hv, lowp, key, ready, sclk, pdat, ddat, doe_n;
	logic pm, lvm, crst, hiz, mce, gpie, wd, bo, b27, lpb, put, ext, mval, slp, swd;
	logic [9:0]   wp;
	logic [13:0]  addr;
	spv_cfg_t     cfg;
	spv_mem_req_t mreq;
	int           err_total = 0;
	int           cmp_count = 0;
	// The line level: the device wins while it drives, otherwise the programmer.
	wire logic sdat = doe_n ? pdat : ddat;
	// Array read data is a fixed pattern of the address.
	wire logic [13:0] rdat = addr ^ 14'h2AAA;
	spv_prog prog (.sclk_out(sclk), .sdat_out(pdat), .sdat_in(sdat));
	spv_core #(.PART_CODE(PC), .REV_CODE(5'h03), .CAL1_WORD(CAL)) dut (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .prog_serial_clock_pin_in(sclk),
		.prog_serial_data_pin_in(sdat), .prog_serial_data_pin_out(ddat),
		.prog_serial_data_pin_oe_n_out(doe_n), .master_clear_pin_hv_in(hv),
		.master_clear_pin_low_in(lowp), .lv_key_ok_in(key), .sleep_in(slp),
		.software_watchdog_enable_in(swd), .software_brownout_enable_in(swd),
		.prog_mode_out(pm), .lv_mode_out(lvm), .core_reset_out(crst), .io_hiz_out(hiz),
		.master_clear_enable_out(mce), .gp_input_enable_out(gpie), .cfg_out(cfg),
		.wp_limit_out(wp), .watchdog_active_out(wd), .brownout_active_out(bo),
		.brownout_2v7_out(b27), .lp_brownout_on_out(lpb), .powerup_timer_on_out(put),
		.ext_clock_sel_out(ext), .mem_rd_addr_out(addr), .mem_rd_data_in(rdat),
		.mem_req_out(mreq), .mem_req_valid_out(mval), .mem_req_ready_in(ready));
	// 200 MHz system clock.
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// Compares a seen value with the expected one and counts both outcomes.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Inputs change 1 ns after the rising edge so no race with the design.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// Bounded wait on the session flag, then the settling gap before serial edges.
	task automatic wait_mode(input logic v);
		int n;
		n = 0;
		while (pm !== v && n < 20) begin
			step(1);
			n++;
		end
		check(pm, v);
		step(6);
	endtask
	// Reads the configuration-space word at 2000h plus an offset.
	task automatic rd_cfg(input int off, output logic [13:0] d);
		prog.load(CMD_LOAD_CFG, 14'h0000);
		repeat (off) prog.send(16'h0006, 6);
		prog.read(d);
	endtask
	// Writes a configuration-space word at 2000h plus an offset, then lets it settle.
	task automatic wr_cfg(input int off, input logic [13:0] v);
		prog.load(CMD_LOAD_CFG, v);
		repeat (off) prog.send(16'h0006, 6);
		prog.send(16'h0008, 6);
		step(4);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// A hang is cut short well beyond the expected run of about 40 us.
	initial begin
		#400_000;
		err_total++;
		give_verdict();
	end
	initial begin : main
		logic [13:0] d;
		sys_rst_in = 1'b1;
		{hv, lowp, key, ready, slp, swd} = 6'b000100;
		repeat (6) @(posedge clk_sys_in);
		#1 sys_rst_in = 1'b0;
		step(4);
		check(cfg, CFG_BLANK);
		check({mce, pm}, 2'b10);
		$display("test reset done");
		hv = 1'b1;
		wait_mode(1'b1);
		check({crst, hiz, addr}, {2'b11, A_ZERO});
		rd_cfg(6, d);
		check(d, {PC, 5'h03});
		rd_cfg(0, d);
		check(d, WORD_BLANK);
		rd_cfg(7, d);
		check(d, CFG_BLANK);
		$display("test identity done");
		// All programmable bits cleared: every field takes its zero meaning.
		wr_cfg(7, 14'h0000);
		check(cfg, CFG_UNIMPL);
		check({wp, b27, lpb, put, ext, wd, bo, mce, gpie}, {10'h200, 8'hA1});
		prog.send(16'h0016, 6);
		prog.read(d);
		check(d, 14'h0000);
		// Watchdog under the software bit, brown-out on only while running.
		wr_cfg(7, 14'h000C);
		{slp, swd} = 2'b11;
		step(1);
		check({wd, bo}, 2'b10);
		{slp, swd} = 2'b00;
		step(1);
		check({wd, bo}, 2'b01);
		$display("test config write done");
		hv = 1'b0;
		wait_mode(1'b0);
		{lowp, key} = 2'b11;
		step(12);
		check(pm, 1'b0);
		{lowp, key} = 2'b00;
		hv = 1'b1;
		wait_mode(1'b1);
		ready = 1'b0;
		prog.send(16'h0009, 6);
		step(4);
		check({cfg, mval, mreq.op}, {CFG_BLANK, 1'b1, OP_BULK});
		ready = 1'b1;
		step(2);
		check(mval, 1'b0);
		rd_cfg(8, d);
		check(d, CAL);
		$display("test erase done");
		prog.send(16'h0016, 6);
		prog.load(CMD_LOAD_PM, 14'h1234);
		step(1);
		ready = 1'b0;
		prog.send(16'h0008, 6);
		step(4);
		check({mval, mreq}, {1'b1, OP_WRITE, A_ZERO, 14'h1234});
		ready = 1'b1;
		prog.read(d);
		check(d, 14'h2AAA);
		// Row erase is queued at the current address.
		step(1);
		ready = 1'b0;
		prog.send(16'h0011, 6);
		step(4);
		check({mval, mreq.op, mreq.addr}, {1'b1, OP_ROW, A_ZERO});
		ready = 1'b1;
		step(1);
		hv = 1'b0;
		wait_mode(1'b0);
		{lowp, key} = 2'b11;
		wait_mode(1'b1);
		key = 1'b0;
		check({lvm, mce, gpie}, 3'b110);
		// A low-voltage session cannot clear its own enable bit.
		wr_cfg(7, 14'h0000);
		check(cfg, 14'h2100);
		lowp = 1'b0;
		wait_mode(1'b0);
		$display("test low-voltage session done");
		give_verdict();
	end
endmodule
`default_nettype wire
